// ---- fsq_pkg.sv ----
package fsq_pkg;

  // Bus window: array words below 0x100, control words above
  localparam logic [8:0]  CTRL_OFFSET   = 9'h100;
  localparam logic [8:0]  UNLOCK_OFFSET = 9'h104;

  // Array shape: two blocks of thirty-two 16-bit words
  localparam int          WORDS      = 64;
  localparam int          BLK_WORDS  = 32;
  localparam logic [15:0] ERASED_VAL = 16'hffff;

  // Control word bit positions
  localparam int BIT_WRITE_EN     = 0;
  localparam int BIT_ERASE_EN     = 1;
  localparam int BIT_BUSY         = 2;
  localparam int BIT_SUPPLY_DROP  = 3;
  localparam int BIT_SUPPLY_OK    = 4;
  localparam int BIT_PW_LO        = 5;
  localparam int BIT_PW_HI        = 6;
  localparam int BIT_DOUBLE       = 7;
  localparam int BIT_BLK_LO       = 8;
  localparam int BIT_BLK_HI       = 9;
  localparam int BIT_MODE_CONFIRM = 10;

  // Reset value, software-writable bits, unlock key
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'h07e3;
  localparam logic [15:0] UNLOCK_KEY   = 16'h1000;

  // Pulse lengths in clock cycles for the two short width codes
  localparam logic [16:0] PULSE_LEN_0 = 17'h00080;
  localparam logic [16:0] PULSE_LEN_1 = 17'h00800;

  // Sequencer states, Gray along idle, half, pulse
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HALF  = 2'b01,
    ST_PULSE = 2'b11
  } fsq_state_t;

  // Bus request held from address phase into data phase
  typedef struct packed {
    logic [8:0] addr;
    logic       write;
    logic       sel;
  } fsq_req_t;

  // Pending program or erase job
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] lo;
    logic [15:0] hi;
    logic        dbl;
    logic        erase;
    logic [1:0]  blk;
  } fsq_job_t;

endpackage

// ---- fsq_pulse_timer.sv ----
`timescale 1ns/1ns
module fsq_pulse_timer (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Control
  input  wire logic        start_in,
  input  wire logic        abort_in,
  input  wire logic [16:0] len_in,
  // Status
  output logic             busy_out,
  output logic             done_out
);

  logic [16:0] cnt_r;
  logic        busy_r;

  // Down counter, busy for exactly len cycles
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      cnt_r  <= 17'h00000;
      busy_r <= 1'b0;
    end else if (abort_in) begin
      busy_r <= 1'b0;
    end else if (start_in && !busy_r) begin
      cnt_r  <= len_in - 17'h00001;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == 17'h00000) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 17'h00001;
      end
    end
  end

  // Last busy cycle, suppressed by abort
  assign busy_out = busy_r;
  assign done_out = busy_r && (cnt_r == 17'h00000) && !abort_in;

endmodule // fsq_pulse_timer

// ---- fsq_array_mem.sv ----
`timescale 1ns/1ns
module fsq_array_mem (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Read port
  input  wire logic        rd_en_in,
  input  wire logic [5:0]  rd_addr_in,
  output logic      [15:0] rd_data_out,
  // Program and erase port
  input  wire logic        prog_en_in,
  input  wire logic        prog_dbl_in,
  input  wire logic [5:0]  prog_addr_in,
  input  wire logic [15:0] prog_lo_in,
  input  wire logic [15:0] prog_hi_in,
  input  wire logic        erase_en_in,
  input  wire logic [1:0]  erase_blk_in
);

  logic [15:0] mem_r [fsq_pkg::WORDS];

  // Cells only lose ones on program, regain them on block erase
  for (genvar i = 0; i < fsq_pkg::WORDS; i++) begin : g_word
    localparam int BLK = i / fsq_pkg::BLK_WORDS;
    always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
        mem_r[i] <= fsq_pkg::ERASED_VAL;
      end else if (erase_en_in && erase_blk_in[BLK]) begin
        mem_r[i] <= fsq_pkg::ERASED_VAL;
      end else if (prog_en_in && prog_addr_in == 6'(i)) begin
        mem_r[i] <= mem_r[i] & prog_lo_in;
      end else if (prog_en_in && prog_dbl_in && (prog_addr_in | 6'h01) == 6'(i)) begin
        mem_r[i] <= mem_r[i] & prog_hi_in;
      end
    end
  end

  // Registered read
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_en_in) begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule // fsq_array_mem

// ---- fsq_sequencer.sv ----
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Function
// - Armed for program, data write to target word starts pulse by itself.
// - Double mode: two writes, even then odd word, programmed together.
// - Two pulse-width bits set the pulse length.
// - Busy reads one during program pulse, clears at its end.
// - Supply-drop reads one if high voltage fell during pulse.
// - Writing control back to reset with write enable clear stops everything.
// - Loading erase setup only arms; no erase without the command write.
// - Write into an armed block starts erase pulse on whole block.
// - Busy reads one during erase pulse, clears when it completes.
// - Clearing control ends erase and verify before normal reads.
// - Control reachable only after an unlock write sequence.
// - Supply-present flag reads one while high voltage is correct.
module fsq_sequencer #(
  parameter logic [16:0] PULSE_LEN_2 = 17'h08000,
  parameter logic [16:0] PULSE_LEN_3 = 17'h10000
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [31:0] hrdata_out,
  // High-voltage supply sense pin
  input  wire logic        vpp_ok_in
);

  fsq_pkg::fsq_req_t   req_r;
  fsq_pkg::fsq_job_t   job_r;
  fsq_pkg::fsq_state_t state_r;
  logic                vpp_meta_r;
  logic                vpp_ok_r;
  logic                key_seen_r;
  logic                unlocked_r;
  logic [15:0]         ctrl_r;
  logic                drop_r;
  logic [15:0]         reg_rd_r;
  logic                rd_arr_r;
  logic [15:0]         mem_q;
  logic [16:0]         pulse_len;
  logic [15:0]         status_word;
  logic                busy;
  logic                done;

  // Supply sense synchroniser
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      vpp_meta_r <= 1'b0;
      vpp_ok_r   <= 1'b0;
    end else begin
      vpp_meta_r <= vpp_ok_in;
      vpp_ok_r   <= vpp_meta_r;
    end
  end

  // Address phase capture; hsize unused, word access only
  wire addr_take = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      req_r <= '0;
    end else if (hready_in) begin
      req_r.sel   <= addr_take;
      req_r.write <= hwrite_in;
      req_r.addr  <= haddr_in[8:0];
    end
  end

  // Data phase write decode
  wire         wr_act  = req_r.sel && req_r.write;
  wire         wr_arr  = wr_act && !req_r.addr[8];
  wire         wr_ctrl = wr_act && (req_r.addr == fsq_pkg::CTRL_OFFSET);
  wire         wr_key  = wr_act && (req_r.addr == fsq_pkg::UNLOCK_OFFSET);
  wire [15:0]  wdata   = hwdata_in[15:0];
  wire [5:0]   waddr   = req_r.addr[7:2];
  wire         key_ok  = (wdata == fsq_pkg::UNLOCK_KEY);

  // Exit: control written with write enable clear
  wire exit_cmd  = wr_ctrl && unlocked_r && !wdata[fsq_pkg::BIT_WRITE_EN];
  wire ctrl_load = wr_ctrl && unlocked_r && wdata[fsq_pkg::BIT_WRITE_EN] && !busy;

  // Unlock: two back-to-back key writes open the control word
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      key_seen_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (exit_cmd) begin
      key_seen_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (wr_act) begin
      key_seen_r <= wr_key && key_ok && !key_seen_r;
      if (wr_key && key_ok && key_seen_r) begin
        unlocked_r <= 1'b1;
      end
    end
  end

  // Control word; ignored while locked
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrl_r <= fsq_pkg::CTRL_RESET;
    end else if (exit_cmd) begin
      ctrl_r <= fsq_pkg::CTRL_RESET;
    end else if (ctrl_load) begin
      ctrl_r <= wdata & fsq_pkg::CTRL_WR_MASK;
    end
  end

  // Command decode against armed setup
  wire armed      = unlocked_r && ctrl_r[fsq_pkg::BIT_WRITE_EN] && ctrl_r[fsq_pkg::BIT_MODE_CONFIRM];
  wire erase_mode = ctrl_r[fsq_pkg::BIT_ERASE_EN];
  wire dbl_mode   = ctrl_r[fsq_pkg::BIT_DOUBLE];
  wire blk_hit    = waddr[5] ? ctrl_r[fsq_pkg::BIT_BLK_HI] : ctrl_r[fsq_pkg::BIT_BLK_LO];
  wire cmd_ok     = wr_arr && armed && !busy;
  wire erase_go   = cmd_ok && erase_mode && blk_hit;
  wire prog_lo    = cmd_ok && !erase_mode && dbl_mode && (state_r == fsq_pkg::ST_IDLE);
  wire prog_go    = cmd_ok && !erase_mode && (!dbl_mode || state_r == fsq_pkg::ST_HALF);
  wire start      = erase_go || prog_go;

  // Sequencer state
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_r <= fsq_pkg::ST_IDLE;
    end else if (exit_cmd || ctrl_load) begin
      state_r <= fsq_pkg::ST_IDLE;
    end else begin
      case (state_r)
        fsq_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= fsq_pkg::ST_PULSE;
          end else if (prog_lo) begin
            state_r <= fsq_pkg::ST_HALF;
          end
        end
        fsq_pkg::ST_HALF: begin
          if (start) begin
            state_r <= fsq_pkg::ST_PULSE;
          end
        end
        fsq_pkg::ST_PULSE: begin
          // Leave on the last pulse cycle, so a prompt next write finds idle
          if (done) begin
            state_r <= fsq_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= fsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Job capture: even word, odd word, or block mask
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      job_r <= '0;
    end else if (erase_go) begin
      job_r.erase <= 1'b1;
      job_r.blk   <= {ctrl_r[fsq_pkg::BIT_BLK_HI], ctrl_r[fsq_pkg::BIT_BLK_LO]};
    end else if (prog_lo) begin
      job_r.erase <= 1'b0;
      job_r.addr  <= {waddr[5:1], 1'b0};
      job_r.lo    <= wdata;
    end else if (prog_go) begin
      job_r.erase <= 1'b0;
      job_r.dbl   <= dbl_mode;
      if (dbl_mode) begin
        job_r.hi <= wdata;
      end else begin
        job_r.addr <= waddr;
        job_r.lo   <= wdata;
      end
    end
  end

  // Pulse length from the two width bits
  always_comb begin
    case ({ctrl_r[fsq_pkg::BIT_PW_HI], ctrl_r[fsq_pkg::BIT_PW_LO]})
      2'b00:   pulse_len = fsq_pkg::PULSE_LEN_0;
      2'b01:   pulse_len = fsq_pkg::PULSE_LEN_1;
      2'b10:   pulse_len = PULSE_LEN_2;
      default: pulse_len = PULSE_LEN_3;
    endcase
  end

  // Pulse timer; exit aborts without committing
  fsq_pulse_timer u_timer (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .start_in (start),
    .abort_in (exit_cmd),
    .len_in   (pulse_len),
    .busy_out (busy),
    .done_out (done)
  );

  // Supply drop: cleared at start, set by any low cycle in pulse
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      drop_r <= 1'b0;
    end else if (busy && !vpp_ok_r) begin
      drop_r <= 1'b1;
    end else if (start) begin
      drop_r <= 1'b0;
    end
  end

  // Flash array, committed at pulse end
  fsq_array_mem u_mem (
    .clock_in     (clock_in),
    .rstn_in      (rstn_in),
    .rd_en_in     (addr_take && !hwrite_in && !haddr_in[8]),
    .rd_addr_in   (haddr_in[7:2]),
    .rd_data_out  (mem_q),
    .prog_en_in   (done && !job_r.erase),
    .prog_dbl_in  (job_r.dbl),
    .prog_addr_in (job_r.addr),
    .prog_lo_in   (job_r.lo),
    .prog_hi_in   (job_r.hi),
    .erase_en_in  (done && job_r.erase),
    .erase_blk_in (job_r.blk)
  );

  // Status view of the control word
  always_comb begin
    status_word                           = ctrl_r;
    status_word[fsq_pkg::BIT_BUSY]        = busy;
    status_word[fsq_pkg::BIT_SUPPLY_DROP] = drop_r;
    status_word[fsq_pkg::BIT_SUPPLY_OK]   = vpp_ok_r;
  end

  // Read data captured at address phase
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      reg_rd_r <= 16'h0000;
      rd_arr_r <= 1'b0;
    end else if (hready_in) begin
      rd_arr_r <= addr_take && !hwrite_in && !haddr_in[8];
      if (addr_take && !hwrite_in && haddr_in[8:0] == fsq_pkg::CTRL_OFFSET && unlocked_r) begin
        reg_rd_r <= status_word;
      end else begin
        reg_rd_r <= 16'h0000;
      end
    end
  end

  // Bus answer: zero wait, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = {16'h0000, rd_arr_r ? mem_q : reg_rd_r};

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  logic [16:0] busy_cnt_r;
  logic [16:0] exp_len_r;

  // Helper: measured and expected pulse length
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      busy_cnt_r <= 17'h00000;
      exp_len_r  <= 17'h00000;
    end else if (start && !busy) begin
      busy_cnt_r <= 17'h00000;
      exp_len_r  <= pulse_len;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r + 17'h00001;
    end
  end

  sequence s_prog_cmd;
    prog_go && !dbl_mode;
  endsequence

  sequence s_pulse_on;
    busy && state_r == fsq_pkg::ST_PULSE;
  endsequence

  // Erase pulse: command write, then busy with the erase job
  sequence s_erase_cmd;
    erase_go;
  endsequence

  sequence s_erase_on;
    busy && job_r.erase && status_word[fsq_pkg::BIT_BUSY];
  endsequence

  // Program side, drop flag, exit, arming, erase start and access checks
  prog_start_a: assert property (s_prog_cmd |=> s_pulse_on ##0 !job_r.erase)
    else $error("program write did not start a pulse");
  dbl_pair_a: assert property (prog_lo |=> state_r == fsq_pkg::ST_HALF && !busy ##0 job_r.lo == $past(wdata))
    else $error("even word did not wait for odd word");
  pulse_len_a: assert property ($fell(busy) && !$past(exit_cmd) |-> busy_cnt_r == exp_len_r)
    else $error("pulse length differs from width select");
  busy_end_a: assert property (done |=> !busy ##0 status_word[fsq_pkg::BIT_BUSY] == 1'b0)
    else $error("busy flag stayed set after pulse end");
  drop_flag_a: assert property (busy && !vpp_ok_r |=> drop_r [*2])
    else $error("supply drop not flagged");
  exit_stop_a: assert property (exit_cmd |=> !busy && !unlocked_r && ctrl_r == fsq_pkg::CTRL_RESET)
    else $error("clearing control did not stop activity");
  arm_only_a: assert property (ctrl_load && !busy |=> !busy ##1 (!busy || $past(start)))
    else $error("loading setup started a pulse");
  erase_whole_a: assert property (erase_go |=> busy && job_r.erase && job_r.blk != 2'b00)
    else $error("erase command did not start block erase");
  locked_ctrl_a: assert property (wr_ctrl && !unlocked_r |=> ctrl_r == $past(ctrl_r))
    else $error("locked control word was written");
  busy_ignore_a: assert property (busy && wr_arr |=> job_r == $past(job_r))
    else $error("command accepted while busy");

  // Erase, exit and supply checks
  erase_busy_a: assert property (s_erase_cmd |=> s_erase_on)
    else $error("busy flag not set during erase pulse");
  erase_end_a: assert property (done && job_r.erase |=> !busy ##0 !status_word[fsq_pkg::BIT_BUSY])
    else $error("busy flag stayed set after erase pulse");
  exit_idle_a: assert property (exit_cmd |=> state_r == fsq_pkg::ST_IDLE && !done)
    else $error("clearing control left the sequencer active");
  supply_ok_a: assert property ($past(rstn_in, 2) && $past(rstn_in) |-> vpp_ok_r == $past(vpp_ok_in, 2))
    else $error("supply flag does not follow the supply pin");

endmodule // fsq_sequencer

// ---- fsq_sequencer_tb_top.sv ----
`timescale 1ns/1ns
module fsq_sequencer_tb_top;
  // Shortened lengths for the two long width codes, run ceiling, bus offsets
  localparam logic [16:0] LEN2  = 17'h00010;
  localparam logic [16:0] LEN3  = 17'h00020;
  localparam int          LIMIT  = 50000;
  localparam int          GAP    = 400;  // 4 us between verify reads
  localparam int          SETTLE = 1000; // 10 us after entering write mode
  localparam logic [31:0] CTRL  = 32'h0000_0100;
  localparam logic [31:0] KEY   = 32'h0000_0104;

  // Expected read result, compared only when chk is set
  typedef struct packed {
    logic        chk;
    logic [31:0] val;
  } fsq_note_t;

  logic        clock_in      = 1'b0;
  logic        rstn_in       = 1'b0;
  logic        hsel_in       = 1'b0;
  logic [31:0] haddr_in      = 32'h0;
  logic [1:0]  htrans_in     = 2'b00;
  logic        hwrite_in     = 1'b0;
  logic [2:0]  hsize_in      = 3'b010;
  logic [31:0] hwdata_in     = 32'h0;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [31:0] hrdata_out;
  logic        vpp_ok_in     = 1'b1;
  logic        rd_pend       = 1'b0;
  int          cyc           = 0;
  int          addr_cyc      = 0;
  int          miscompares   = 0;
  int          check_count   = 0;
  fsq_note_t   notes[$];

  fsq_sequencer #(.PULSE_LEN_2(LEN2), .PULSE_LEN_3(LEN3)) i_fsq_sequencer (
    .clock_in(clock_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .vpp_ok_in(vpp_ok_in));

  // Clock generation
  always #5 clock_in = ~clock_in;

  // Verdict and end of run
  task automatic results();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare of a 32-bit result
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Cycle counter and hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      results();
    end
  end

  // Read data watcher: takes the oldest note at each read data phase end
  always @(posedge clock_in) begin
    fsq_note_t note;
    if (rd_pend && hreadyout_out === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.chk) cmp32("read data", note.val, hrdata_out);
    end
    if (hreadyout_out === 1'b1) rd_pend = hsel_in & htrans_in[1] & ~hwrite_in & rstn_in;
  end

  // Single word transfer: address phase, then data phase, each until hready
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     input logic chk, input logic [31:0] exp, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clock_in);
    hsel_in   <= 1'b1;
    haddr_in  <= addr;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    hsize_in  <= 3'b010;
    do begin
      @(posedge clock_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 100);
    addr_cyc = cyc;
    if (!wr) notes.push_back({chk, exp});
    htrans_in <= 2'b00;
    hwdata_in <= wdata;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 100);
    rdata = hrdata_out;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 1'b0, 32'h0, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 1'b1, e, r);
  endtask

  task automatic unlock();
    wr(KEY, 32'h0000_1000);
    wr(KEY, 32'h0000_1000);
  endtask

  // Poll busy until clear; returns cycle of the address phase that saw it clear
  task automatic wait_idle(output int at);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      bus(1'b0, CTRL, 32'h0, 1'b0, 32'h0, r);
      n++;
    end while (r[2] !== 1'b0 && n < 1000);
    at = addr_cyc;
  endtask

  // Pulse length check with a small window for polling granularity
  task automatic len_chk(input int t0, input int t1, input int len);
    cmp32("pulse length", 32'h1, {31'h0, (t1 - t0 >= len - 1) && (t1 - t0 <= len + 5)});
  endtask

  // Main sequence
  initial begin
    logic [31:0] ctl;
    logic [31:0] a;
    logic [31:0] da;
    logic [31:0] db;
    logic [31:0] d0;
    logic [31:0] dw;
    int          t0;
    int          t1;
    int          lens[4];
    int          pulses;
    logic [31:0] r;
    lens = '{128, 2048, int'(LEN2), int'(LEN3)};
    void'($urandom(32'h712a));
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    // Locked after reset; bad unlock and locked writes have no effect
    rd(CTRL, 32'h0);
    wr(CTRL, 32'h0481);
    wr(KEY, 32'h0000_1000);
    wr(32'h0, 32'h0);
    wr(KEY, 32'h0000_1000);
    rd(CTRL, 32'h0);
    rd(32'h0, 32'hffff);
    unlock();
    rd(CTRL, 32'h10);
    rd(32'h1fc, 32'h0);
    vpp_ok_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(CTRL, 32'h0);
    vpp_ok_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    // Single word program with every width code; intruding write while busy
    for (int code = 0; code < 4; code++) begin
      ctl = 32'h0401 | (32'(code) << 5);
      a   = 32'h080 + 32'(code * 8);
      dw  = {16'h0, 16'($urandom())};
      if (code == 0) d0 = dw;
      wr(CTRL, ctl);
      wr(a, dw);
      t0 = addr_cyc + 1;
      wr(a + 32'h4, 32'h0);
      rd(CTRL, ctl | 32'h14);
      if (code == 1) begin
        vpp_ok_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        vpp_ok_in <= 1'b1;
      end
      wait_idle(t1);
      len_chk(t0, t1, lens[code]);
      rd(CTRL, ctl | 32'h10 | ((code == 1) ? 32'h8 : 32'h0));
      rd(a, dw);
      rd(a + 32'h4, 32'hffff);
    end
    // Double word: even then odd, nothing starts after the first write
    da = {16'h0, 16'($urandom())};
    db = {16'h0, 16'($urandom())};
    wr(CTRL, 32'h0481);
    wr(32'h028, da);
    rd(CTRL, 32'h0491);
    wr(32'h02c, db);
    wait_idle(t1);
    rd(32'h028, da);
    rd(32'h02c, db);
    // Clearing control mid-pulse aborts without commit and relocks
    wr(CTRL, 32'h0421);
    wr(32'h030, 32'h0);
    wr(CTRL, 32'h0);
    rd(CTRL, 32'h0);
    rd(32'h030, 32'hffff);
    // Pre-erase: program every word of block 0 to zero, verified, pulses counted
    unlock();
    wr(CTRL, 32'h0401);
    repeat (SETTLE) @(posedge clock_in);
    rd(CTRL, 32'h0411);
    for (int w = 0; w < 32; w++) begin
      pulses = 0;
      do begin
        wr(32'(w * 4), 32'h0);
        pulses++;
        wait_idle(t1);
        rd(CTRL, 32'h0411);
        rd(32'(w * 4), 32'h0);
        repeat (GAP) @(posedge clock_in);
        bus(1'b0, 32'(w * 4), 32'h0, 1'b1, 32'h0, r);
      end while (r !== 32'h0 && pulses < 3);
    end
    // Erase of block 0: setup only arms, write outside the block is ignored
    wr(CTRL, 32'h0543);
    rd(32'h028, 32'h0);
    wr(32'h080, 32'h0);
    rd(CTRL, 32'h0553);
    wr(32'h004, 32'h0);
    t0 = addr_cyc + 1;
    rd(CTRL, 32'h0557);
    wait_idle(t1);
    len_chk(t0, t1, int'(LEN2));
    // Erase verify walk: two spaced reads per word, extra block pulse on mismatch
    pulses = 1;
    for (int w = 0; w < 32; w++) begin
      r = 32'hffff;
      do begin
        if (r !== 32'hffff) begin
          wr(32'h004, 32'h0);
          pulses++;
          wait_idle(t1);
        end
        rd(32'(w * 4), 32'hffff);
        repeat (GAP) @(posedge clock_in);
        bus(1'b0, 32'(w * 4), 32'h0, 1'b1, 32'hffff, r);
      end while (r !== 32'hffff && pulses < 4);
    end
    rd(CTRL, 32'h0553);
    rd(32'h028, 32'hffff);
    rd(32'h02c, 32'hffff);
    rd(32'h080, d0);
    wr(CTRL, 32'h0);
    rd(CTRL, 32'h0);
    repeat (2) @(posedge clock_in);
    results();
  end
endmodule // fsq_sequencer_tb_top
